// file: verilog/uto_top.v
// Purpose: APB register file and receive timeout detection for two UART channels
// Assumes: Receiver events, bit ticks and fifo levels come from logic on clk
// Notes: Zero-wait APB slave, pready high in the cycle after setup
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uto_regs.vh"

// Functional notes
// R01: The timeout settings act only while the channel's fifo mode select bit is 1.
// R02: After a stop bit, a timeout event is raised if the fifo holds data and no start bit came in time.
// R03: Bit 7 of the timeout register enables the counter; while clear no timeout event occurs.
// R04: The five-bit wait code selects 32 minus code byte-times of 8 bit periods each.
// R05: The timeout register may be written whole as a byte or one bit at a time.
// R06: At expiry the counter clears its count and stops, and restarts after the next stop bit.
module uto_top #(
  parameter ADDR_W = 12,
  parameter NCH = 2,
  parameter CNT_W = 9
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  input wire ce,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Receiver events per channel
  input wire [NCH-1:0] bit_tick,
  input wire [NCH-1:0] stop_rcvd,
  input wire [NCH-1:0] start_det,
  input wire [NCH-1:0] fifo_has_data,
  // Interrupts
  output reg [NCH-1:0] rx_timeout_irq,
  output reg irq
);

  ////////////////////////////////////////////////////////////////////////////
  localparam [31:0] A_CFG0 = `UTO_IDX_CFG0 << 2;
  localparam [31:0] A_CFG1 = `UTO_IDX_CFG1 << 2;
  localparam [31:0] A_CTRL0 = `UTO_IDX_CTRL0 << 2;
  localparam [31:0] A_CTRL1 = `UTO_IDX_CTRL1 << 2;
  localparam [31:0] A_STAT = `UTO_IDX_STAT << 2;
  localparam [31:0] A_MASK = `UTO_IDX_MASK << 2;
  localparam [31:0] A_BITOP = `UTO_IDX_BITOP << 2;

  reg [7:0] cfg_reg [0:1];
  reg [7:0] ctrl_reg [0:1];
  reg [NCH-1:0] stat_reg;
  reg [NCH-1:0] mask_reg;
  reg [NCH-1:0] stat_next;
  reg [31:0] rdata_next;
  reg hit_next;
  wire [NCH-1:0] to_pulse;
  wire setup_w;
  wire done_w;
  wire wr_w;
  wire [2:0] bit_idx_w;
  wire bit_ch_w;
  // Decoded selects and helpers
  wire sel_cfg0_w;
  wire sel_cfg1_w;
  wire sel_ctrl0_w;
  wire sel_ctrl1_w;
  wire sel_stat_w;
  wire sel_mask_w;
  wire sel_bitop_w;
  wire [7:0] bit_mask_w;
  wire bit_ok_w;
  wire rd_stat_w;
  wire [NCH-1:0] irq_src_w;

  assign setup_w = psel & ~penable;
  assign done_w = psel & penable & pready;
  assign wr_w = done_w & pwrite & pstrb[0];
  assign bit_idx_w = pwdata[`UTO_BITOP_IDX_MSB:`UTO_BITOP_IDX_LSB];
  assign bit_ch_w = pwdata[`UTO_BITOP_CH_BIT];

  // Register selects on the low address bits
  assign sel_cfg0_w = (paddr == A_CFG0[ADDR_W-1:0]);
  assign sel_cfg1_w = (paddr == A_CFG1[ADDR_W-1:0]);
  assign sel_ctrl0_w = (paddr == A_CTRL0[ADDR_W-1:0]);
  assign sel_ctrl1_w = (paddr == A_CTRL1[ADDR_W-1:0]);
  assign sel_stat_w = (paddr == A_STAT[ADDR_W-1:0]);
  assign sel_mask_w = (paddr == A_MASK[ADDR_W-1:0]);
  assign sel_bitop_w = (paddr == A_BITOP[ADDR_W-1:0]);
  // Bit access reaches only the writable bits of the timeout register
  assign bit_mask_w = 8'h01 << bit_idx_w;
  assign bit_ok_w = |(bit_mask_w & `UTO_CFG_WMASK);
  assign rd_stat_w = done_w & ~pwrite & sel_stat_w;
  assign irq_src_w = stat_next & mask_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode and read data
  always @* begin
    rdata_next = 32'h00000000;
    hit_next = 1'b1;
    if (sel_cfg0_w) begin
      rdata_next[7:0] = cfg_reg[0];
    end else if (sel_cfg1_w) begin
      rdata_next[7:0] = cfg_reg[1];
    end else if (sel_ctrl0_w) begin
      rdata_next[7:0] = ctrl_reg[0];
    end else if (sel_ctrl1_w) begin
      rdata_next[7:0] = ctrl_reg[1];
    end else if (sel_stat_w) begin
      rdata_next[NCH-1:0] = stat_reg;
    end else if (sel_mask_w) begin
      rdata_next[NCH-1:0] = mask_reg;
    end else if (sel_bitop_w) begin
      // Bit access register reads as zero
      rdata_next = 32'h00000000;
    end else begin
      hit_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB handshake: answer in the cycle after setup
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (ce) begin
      if (setup_w) begin
        pready <= 1'b1;
        prdata <= pwrite ? 32'h00000000 : rdata_next;
        pslverr <= ~hit_next;
      end else begin
        pready <= 1'b0;
        prdata <= 32'h00000000;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cfg_reg[0] <= `UTO_CFG_RESET;
      cfg_reg[1] <= `UTO_CFG_RESET;
      ctrl_reg[0] <= `UTO_CTRL_RESET;
      ctrl_reg[1] <= `UTO_CTRL_RESET;
      mask_reg <= {NCH{1'b0}};
    end else if (ce && wr_w) begin
      if (sel_cfg0_w) begin
        cfg_reg[0] <= pwdata[7:0] & `UTO_CFG_WMASK; // [R05]
      end
      if (sel_cfg1_w) begin
        cfg_reg[1] <= pwdata[7:0] & `UTO_CFG_WMASK; // [R05]
      end
      if (sel_ctrl0_w) begin
        ctrl_reg[0] <= pwdata[7:0] & `UTO_CTRL_WMASK;
      end
      if (sel_ctrl1_w) begin
        ctrl_reg[1] <= pwdata[7:0] & `UTO_CTRL_WMASK;
      end
      if (sel_mask_w) begin
        mask_reg <= pwdata[NCH-1:0];
      end
      // Reserved bits of the timeout register never hold a one
      if (sel_bitop_w && bit_ok_w) begin
        cfg_reg[bit_ch_w][bit_idx_w] <= pwdata[`UTO_BITOP_VAL_BIT]; // [R05]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-channel counters
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire act_w;
      // Counter runs only in fifo mode with the enable bit set
      assign act_w = ctrl_reg[g][`UTO_MODE_BIT] & cfg_reg[g][`UTO_TCE_BIT]; // [R01] [R03]
      uto_chan #(
        .CNT_W(CNT_W)
      ) u_chan (
        .clk(clk),
        .rstn(rstn),
        .ce(ce),
        .active(act_w),
        .wait_time_code(cfg_reg[g][`UTO_CODE_MSB:`UTO_CODE_LSB]), // [R04]
        .bit_tick(bit_tick[g]),
        .stop_rcvd(stop_rcvd[g]),
        .start_det(start_det[g]),
        .fifo_has_data(fifo_has_data[g]),
        .timeout_pulse(to_pulse[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Sticky status, cleared by read of the bits returned; a new event wins
  always @* begin
    stat_next = stat_reg;
    if (rd_stat_w) begin
      stat_next = stat_reg & ~prdata[NCH-1:0];
    end
    stat_next = stat_next | to_pulse; // [R02]
  end

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stat_reg <= {NCH{1'b0}};
      rx_timeout_irq <= {NCH{1'b0}};
      irq <= 1'b0;
    end else if (ce) begin
      stat_reg <= stat_next;
      rx_timeout_irq <= to_pulse; // [R02]
      irq <= |irq_src_w;
    end
  end

endmodule
`default_nettype wire

// file: verilog/uto_regs.vh
// Purpose: Register indices, field positions and reset values of the receive timeout block
// Assumes: Byte address of a register is four times its index
// Notes: Definitions only
`ifndef UTO_REGS_VH
`define UTO_REGS_VH

// Register indices
`define UTO_IDX_CFG0 32'hFFFFFA0B
`define UTO_IDX_CFG1 32'hFFFFFA2B
`define UTO_IDX_CTRL0 32'hFFFFFA40
`define UTO_IDX_CTRL1 32'hFFFFFA41
`define UTO_IDX_STAT 32'hFFFFFA42
`define UTO_IDX_MASK 32'hFFFFFA43
`define UTO_IDX_BITOP 32'hFFFFFA44

// Timeout configuration fields
`define UTO_TCE_BIT 7
`define UTO_CODE_MSB 4
`define UTO_CODE_LSB 0
`define UTO_CFG_WMASK 8'h9F
`define UTO_CFG_RESET 8'h00

// Fifo control zero fields
`define UTO_MODE_BIT 7
`define UTO_CTRL_WMASK 8'h80
`define UTO_CTRL_RESET 8'h00

// Bit access register fields
`define UTO_BITOP_IDX_MSB 2
`define UTO_BITOP_IDX_LSB 0
`define UTO_BITOP_VAL_BIT 3
`define UTO_BITOP_CH_BIT 4

// Timing
`define UTO_BITS_PER_BYTE 9'h008
`define UTO_BYTES_MAX 6'h20

`endif

// file: verilog/uto_chan.v
// Purpose: Next-data wait counter of one receive channel
// Assumes: Event and tick inputs are one-cycle pulses from logic on clk
// Notes: Counts bit periods from a stop bit until a start bit or expiry
`timescale 1ns/1ps
`default_nettype none
`include "uto_regs.vh"

module uto_chan #(
  parameter CNT_W = 9
) (
  // Clock and reset
  input wire clk,
  input wire rstn,
  input wire ce,
  // Configuration
  input wire active,
  input wire [4:0] wait_time_code,
  // Receiver events
  input wire bit_tick,
  input wire stop_rcvd,
  input wire start_det,
  input wire fifo_has_data,
  // Result
  output reg timeout_pulse
);

  wire [5:0] bytes_w;
  wire [CNT_W-1:0] limit_w;
  reg [CNT_W-1:0] count_reg;
  reg run_reg;

  // Wait is (32 - code) bytes of 8 bit periods
  assign bytes_w = `UTO_BYTES_MAX - {1'b0, wait_time_code};
  assign limit_w = {{(CNT_W-6){1'b0}}, bytes_w} * `UTO_BITS_PER_BYTE;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= {CNT_W{1'b0}};
      run_reg <= 1'b0;
      timeout_pulse <= 1'b0;
    end else if (ce) begin
      timeout_pulse <= 1'b0;
      if (!active) begin
        count_reg <= {CNT_W{1'b0}};
        run_reg <= 1'b0;
      end else if (start_det) begin
        count_reg <= {CNT_W{1'b0}};
        run_reg <= 1'b0;
      end else if (stop_rcvd) begin
        count_reg <= {CNT_W{1'b0}};
        run_reg <= 1'b1;
      end else if (run_reg && bit_tick) begin
        if (count_reg + 1'b1 == limit_w) begin
          count_reg <= {CNT_W{1'b0}}; // [R06]
          run_reg <= 1'b0; // [R06]
          timeout_pulse <= fifo_has_data; // [R02]
        end else begin
          count_reg <= count_reg + 1'b1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// file: tb/uto_checker.sv
// Purpose: Port assertions of the receive timeout block
// Assumes: Two channels
// Notes: Bound into uto_top
`timescale 1ns/1ps
`default_nettype none
module uto_checker (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Bus
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // Events
  input wire logic [1:0] stop_rcvd,
  input wire logic [1:0] start_det,
  input wire logic [1:0] fifo_has_data,
  input wire logic [1:0] rx_timeout_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_ACC: assert property (psel && !penable |=> pready)
    else $error("no answer");
  AST_ONE: assert property (pready |=> !pready)
    else $error("long ready");
  AST_ERR: assert property (pslverr |-> pready)
    else $error("stray error");
  AST_DATA: assert property (rx_timeout_irq[0] |-> $past(fifo_has_data[0], 2))
    else $error("event without data");
  AST_GAP: assert property (rx_timeout_irq[0] |-> !$past(start_det[0], 2))
    else $error("event after start");
  AST_P0: assert property (rx_timeout_irq[0] |=> !rx_timeout_irq[0])
    else $error("long event 0");
  AST_P1: assert property (rx_timeout_irq[1] |=> !rx_timeout_irq[1])
    else $error("long event 1");
  cover property (rx_timeout_irq[0]);
  cover property (rx_timeout_irq[1]);
  cover property (pslverr);
endmodule
bind uto_top uto_checker uto_checker_i (.clk(clk), .rstn(rstn), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .stop_rcvd(stop_rcvd),
  .start_det(start_det), .fifo_has_data(fifo_has_data), .rx_timeout_irq(rx_timeout_irq));
`default_nettype wire

// file: tb/uto_rxmodel.sv
// Purpose: Remote transmitter events seen by the receiver
// Assumes: Bit period of DIV clocks
// Notes: Stop and start pulses issued by task
`timescale 1ns/1ps
`default_nettype none
module uto_rxmodel #(
  parameter int DIV = 3
) (
  // Clock
  input wire logic clk,
  // Events
  output logic [1:0] bit_tick,
  output logic [1:0] stop_rcvd,
  output logic [1:0] start_det
);
  logic [3:0] div_reg = 4'h0;
  initial begin
    bit_tick = 2'h0;
    stop_rcvd = 2'h0;
    start_det = 2'h0;
  end
  always @(posedge clk) begin
    div_reg <= (div_reg == 4'(DIV - 1)) ? 4'h0 : div_reg + 4'h1;
    bit_tick <= {2{div_reg == 4'h0}};
  end
  // One-clock stop or start pulse
  task automatic pulse(input logic st, input int ch);
    @(posedge clk);
    if (st) start_det[ch] <= 1'b1;
    else stop_rcvd[ch] <= 1'b1;
    @(posedge clk);
    start_det <= 2'h0;
    stop_rcvd <= 2'h0;
  endtask
endmodule
`default_nettype wire

// file: tb/uto_top_tb.sv
// Purpose: Self-checking bench of the receive timeout block
// Assumes: ce held high
// Notes: Bit ticks up to the event are counted exactly
`timescale 1ns/1ps
`default_nettype none
module uto_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [1:0] fifo = 2'h0;
  logic [3:0] strb = 4'hF;
  logic [31:0] prdata, rdata;
  logic pready, pslverr, irq, er, seen, irq_at;
  logic [1:0] tick, stop, start, rx_irq;
  logic [4:0] codes [4] = '{5'h1F, 5'h1E, 5'h10, 5'h00};
  int n_errors = 0;
  int n_compared = 0;
  int n;
  uto_top uto_top_i (.clk(clk), .rstn(rstn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(strb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .bit_tick(tick), .stop_rcvd(stop),
    .start_det(start), .fifo_has_data(fifo), .rx_timeout_irq(rx_irq), .irq(irq));
  uto_rxmodel uto_rxmodel_i (.clk(clk), .bit_tick(tick), .stop_rcvd(stop), .start_det(start));
  initial forever #25 clk = ~clk;
  task close_out;
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string s, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", s, e, g);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1) begin
      n_errors++;
      close_out;
    end
    rdata = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk("read", e, rdata);
  endtask
  task wto(input int ch);
    seen = 1'b0;
    n = 0;
    for (int c = 0; c < 1000 && !seen; c++) begin
      @(negedge clk);
      if (rx_irq[ch] === 1'b1) begin
        seen = 1'b1;
        irq_at = irq;
      end else n += int'(tick[ch]);
    end
    @(posedge clk);
  endtask
  task shot(input int ch, input logic e);
    uto_rxmodel_i.pulse(1'b0, ch);
    wto(ch);
    chk("event", {31'h0, e}, {31'h0, seen});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    rd(12'h82C, 32'h0);
    rd(12'h8AC, 32'h0);
    wr(12'h82C, 32'hFF);
    rd(12'h82C, 32'h9F);
    strb <= 4'h0;
    wr(12'h82C, 32'h0);
    strb <= 4'hF;
    rd(12'h82C, 32'h9F);
    wr(12'h910, 32'h1F);
    wr(12'h910, 32'h18);
    rd(12'h8AC, 32'h81);
    apb(1'b0, 12'h100, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    wr(12'h900, 32'h80);
    wr(12'h90C, 32'h3);
    fifo <= 2'h3;
    foreach (codes[i]) begin
      wr(12'h82C, {24'h0, 3'h4, codes[i]});
      shot(0, 1'b1);
      chk("ticks", 32'((32 - codes[i]) * 8), 32'(n));
      chk("irq", 32'h1, {31'h0, irq_at});
    end
    rd(12'h908, 32'h1);
    rd(12'h908, 32'h0);
    fifo <= 2'h2;
    shot(0, 1'b0);
    fifo <= 2'h3;
    wto(0);
    chk("late", 32'h0, {31'h0, seen});
    uto_rxmodel_i.pulse(1'b0, 0);
    uto_rxmodel_i.pulse(1'b1, 0);
    wto(0);
    chk("start", 32'h0, {31'h0, seen});
    wr(12'h82C, 32'h1F);
    shot(0, 1'b0);
    wr(12'h82C, 32'h9F);
    wr(12'h900, 32'h0);
    shot(0, 1'b0);
    wr(12'h904, 32'h80);
    wr(12'h90C, 32'h0);
    shot(1, 1'b1);
    chk("ticks1", 32'd248, 32'(n));
    chk("masked", 32'h0, {31'h0, irq_at});
    wr(12'h90C, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq", 32'h1, {31'h0, irq});
    rd(12'h908, 32'h2);
    repeat (2) @(posedge clk);
    chk("irq", 32'h0, {31'h0, irq});
    close_out;
  end
endmodule
`default_nettype wire
